//--- tes_defines.svh
/*
 * Register indices, field positions, reset values, method codes and
 * timing counts of the 212 kbit/s transmit edge shaper.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef TES_DEFINES_SVH
`define TES_DEFINES_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define TES_IDX_SELECT       6'h19
`define TES_IDX_PARAM        6'h1A
`define TES_IDX_DURATION     6'h1B
`define TES_IDX_DEPTH        6'h1C
`define TES_IDX_STATUS       6'h3F

// ****************************************************************
// reset values
// ****************************************************************
`define TES_RST_SELECT       8'h11
`define TES_RST_PARAM        8'h00
`define TES_RST_DURATION     8'h08
`define TES_RST_DEPTH        8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define TES_FALL_METHOD      7:4
`define TES_RISE_METHOD      3:0
`define TES_FALL_TC          6:4
`define TES_RISE_TC          2:0
`define TES_STRETCH          7
`define TES_NSTATES          4:0
`define TES_STAT_PHASE       1:0
`define TES_STAT_MOD         2
`define TES_STAT_K           7:3

// ****************************************************************
// method codes and levels
// ****************************************************************
`define TES_M_LIN1           4'h1
`define TES_M_LIN2           4'h2
`define TES_M_LIN3           4'h3
`define TES_M_LUT            4'h4
`define TES_M_LUT_ADPT_CORR  4'h5
`define TES_M_LUT_ADPT       4'h6
`define TES_FULL_AMP         8'hFF
`define TES_SUPPLY_REF       8'h80

// ****************************************************************
// carrier cycles per transition state
// ****************************************************************
`define TES_CYC_PER_STATE    2'h1
`define TES_CYC_PER_STATE_X2 2'h2

`endif

//--- tes_pkg.sv
/*
 * Types shared by the edge shaper modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tes_pkg;

    typedef enum logic [1:0] {
        PH_HIGH,
        PH_FALL,
        PH_LOW,
        PH_RISE
    } tes_phase_t;

    typedef struct packed {
        logic [7:0] select;
        logic [7:0] param;
        logic [7:0] duration;
        logic [7:0] depth;
    } tes_cfg_t;

    typedef struct packed {
        logic [3:0] method;
        logic [2:0] tc;
    } tes_edge_cfg_t;

    typedef struct packed {
        logic meta;
        logic q;
    } tes_sync_t;

    typedef struct packed {
        tes_cfg_t   cfg;
        tes_phase_t phase;
        logic [4:0] k;
        logic [1:0] ticks;
        logic [7:0] amp;
        logic       busy;
        logic       ack;
        logic [31:0] rdat;
    } tes_state_t;

endpackage

//--- tes_sync2.sv
/*
 * Two-flop synchroniser for one level from outside the clock domain.
 * Assumes the level is stable for several clocks between changes.
 */
`timescale 1ns/1ps
`default_nettype none

module tes_sync2
    import tes_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);

    tes_sync_t s;
    tes_sync_t nx;

    // first stage feeds only the second stage
    always_comb begin
        nx.meta = din;
        nx.q    = s.meta;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= nx;
        end
    end

    assign dout = s.q;

endmodule

`default_nettype wire

//--- tes_edge_ramp.sv
/*
 * Amplitude of one envelope edge at transition state k of n.
 * Pure combinational; the caller registers the result.
 * Assumes 1 <= k <= n while an edge is in progress.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tes_defines.svh"

module tes_edge_ramp
    import tes_pkg::*;
(
    input  wire tes_edge_cfg_t ecfg,
    input  wire logic [4:0]    k,
    input  wire logic [4:0]    n,
    input  wire logic [7:0]    start_lvl,
    input  wire logic [7:0]    stop_lvl,
    input  wire logic [7:0]    supply,
    output logic [7:0]         amp
);

    // entry 7 in the top byte; each table ends at full scale
    localparam logic [3:0][63:0] LUTS = {
        64'hFFB88054341C0C04,
        64'hFFF8EEE0CCB08850,
        64'hFFE8C89868381808,
        64'hFFE0C0A080604020
    };

    logic [7:0]  f;
    logic [7:0]  g;
    logic [7:0]  k1;
    logic [7:0]  k2;
    logic [15:0] prod;
    logic [15:0] blend;
    logic [8:0]  sum;

    always_comb begin
        f     = `TES_FULL_AMP;
        g     = `TES_FULL_AMP;
        k1    = 8'h00;
        k2    = 8'h00;
        prod  = 16'h0000;
        sum   = 9'h000;
        if (n != 5'h00 && k < n) begin
            f = 8'((13'(k) * 13'hFF) / 13'(n));
        end
        case (ecfg.method)
            `TES_M_LIN1: begin
                g = f; // R3
            end
            `TES_M_LIN2: begin
                // time constant moves the knee level
                k1 = 8'h80 + {1'b0, ecfg.tc, 4'h0}; // R7 R9
                if (f < 8'h80) begin
                    g = 8'((16'(f) * 16'(k1)) >> 7);
                end else begin
                    g = k1 + 8'((16'(f - 8'h80) * 16'(8'hFF - k1)) >> 7);
                end
            end
            `TES_M_LIN3: begin
                k1 = 8'h40 + {2'h0, ecfg.tc, 3'h0};
                k2 = 8'hC0 + {3'h0, ecfg.tc, 2'h0};
                if (f < 8'h40) begin
                    g = 8'((16'(f) * 16'(k1)) >> 6);
                end else if (f < 8'hC0) begin
                    g = k1 + 8'((16'(f - 8'h40) * 16'(k2 - k1)) >> 7);
                end else begin
                    g = k2 + 8'((16'(f - 8'hC0) * 16'(8'hFF - k2)) >> 6);
                end
            end
            `TES_M_LUT, `TES_M_LUT_ADPT_CORR, `TES_M_LUT_ADPT: begin
                // table index bit 2 is ignored: only tables 0..3 exist
                g = LUTS[ecfg.tc[1:0]][{f[7:5], 3'h0} +: 8]; // R4 R8 R10
            end
            default: begin
                g = `TES_FULL_AMP; // R15
            end
        endcase
        // adaptation never moves the edge's end point
        if ((ecfg.method == `TES_M_LUT_ADPT_CORR
             || ecfg.method == `TES_M_LUT_ADPT) && f != `TES_FULL_AMP) begin
            if (supply < `TES_SUPPLY_REF) begin
                prod = 16'(g) * 16'(`TES_SUPPLY_REF - supply); // R5 R6
                sum  = 9'(g) + 9'(prod[15:8]);
            end else begin
                prod = 16'(g) * 16'(supply - `TES_SUPPLY_REF);
                sum  = 9'(g) - 9'(prod[15:8]);
            end
            if (ecfg.method == `TES_M_LUT_ADPT_CORR && !sum[8]) begin
                sum = sum + 9'(prod[7]); // R5
            end
            g = sum[8] ? `TES_FULL_AMP : sum[7:0];
        end
        if (f == `TES_FULL_AMP) begin
            g = `TES_FULL_AMP;
        end
        blend = 16'(start_lvl) * 16'(8'hFF - g) + 16'(stop_lvl) * 16'(g);
        amp   = 8'(blend / 16'h00FF);
    end

endmodule

`default_nettype wire

//--- tes_edge_shaper.sv
/*
 * Transmit envelope edge shaper, type A 212 kbit/s, with its
 * classic Wishbone register slave.
 * Assumes carrier_tick is a one-clock pulse per carrier cycle from
 * logic on mclk, power_amp_supply a same-clock level code, and
 * mod_req_pin an asynchronous pin level.
 */
// Summary of operation
// [R1] falling-edge method comes from select register bits 7 to 4
// [R2] rising-edge method comes from select bits 3 to 0, independently
// [R3] codes 1, 2, 3 give one, two or three linear ramp segments
// [R4] code 4 uses a lookup table with no supply adaptation
// [R5] code 5 uses a table, supply adaptation and a correction step
// [R6] code 6 uses a table and supply adaptation without correction
// [R7] falling parameter bits 6 to 4 are the time constant, linear methods
// [R8] falling parameter bits 6 to 4 pick table 0 to 3, table methods
// [R9] rising parameter bits 2 to 0 are the time constant, linear methods
// [R10] rising parameter bits 2 to 0 pick table 0 to 3, table methods
// [R11] duration bit 7 doubles both edges by stretching every state
// [R12] stretch clear: each transition state lasts one carrier cycle
// [R13] stretch set: each transition state lasts two carrier cycles
// [R14] duration bits 4 to 0 count active states, same for both edges
// [R15] reserved codes and bits are ignored; software must not use them
// [R16] depth byte maps linearly: 0 is no carrier, 255 full carrier
`timescale 1ns/1ps
`default_nettype none
`include "tes_defines.svh"

module tes_edge_shaper
    import tes_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        mod_req_pin,
    input  wire logic        carrier_tick,
    input  wire logic [7:0]  power_amp_supply,
    output logic [7:0]       amp_out,
    output logic             edge_busy
);

    // ****************************************************************
    // state and wiring
    // ****************************************************************
    tes_state_t    s;
    tes_state_t    nx;
    tes_edge_cfg_t fall_cfg;
    tes_edge_cfg_t rise_cfg;
    logic          mod_sync;
    logic [7:0]    fall_amp;
    logic [7:0]    rise_amp;
    logic [4:0]    n_states;
    logic          stretch;
    logic [1:0]    per_state;
    logic          adv;
    logic [5:0]    idx;
    logic          req;

    tes_sync2 u_mod_sync (
        .mclk (mclk),
        .rst  (rst),
        .din  (mod_req_pin),
        .dout (mod_sync)
    );

    // edges read live settings; rewriting mid-edge takes effect at once
    assign fall_cfg.method = s.cfg.select[`TES_FALL_METHOD]; // R1
    assign fall_cfg.tc     = s.cfg.param[`TES_FALL_TC];      // R7 R8
    assign rise_cfg.method = s.cfg.select[`TES_RISE_METHOD]; // R2
    assign rise_cfg.tc     = s.cfg.param[`TES_RISE_TC];      // R9 R10

    tes_edge_ramp u_fall (
        .ecfg      (fall_cfg),
        .k         (s.k),
        .n         (n_states),
        .start_lvl (`TES_FULL_AMP),
        .stop_lvl  (s.cfg.depth),
        .supply    (power_amp_supply),
        .amp       (fall_amp)
    );

    tes_edge_ramp u_rise (
        .ecfg      (rise_cfg),
        .k         (s.k),
        .n         (n_states),
        .start_lvl (s.cfg.depth),
        .stop_lvl  (`TES_FULL_AMP),
        .supply    (power_amp_supply),
        .amp       (rise_amp)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    assign n_states  = s.cfg.duration[`TES_NSTATES]; // R14
    assign stretch   = s.cfg.duration[`TES_STRETCH];  // R11
    assign per_state = stretch ? `TES_CYC_PER_STATE_X2
                               : `TES_CYC_PER_STATE; // R12 R13
    assign adv       = carrier_tick && (s.ticks + 2'h1 >= per_state);
    assign idx       = wb_adr_i[7:2];
    assign req       = wb_cyc_i && wb_stb_i && !s.ack;

    always_comb begin
        nx     = s;
        nx.ack = 1'b0;
        // bus slave: one answer, registered a cycle after the request; unmapped reads give zero
        if (req) begin
            nx.ack  = 1'b1;
            nx.rdat = 32'h0000_0000;
            if (idx == `TES_IDX_SELECT) begin
                nx.rdat[7:0] = s.cfg.select;
                if (wb_we_i && wb_sel_i[0]) begin
                    nx.cfg.select = wb_dat_i[7:0];
                end
            end else if (idx == `TES_IDX_PARAM) begin
                nx.rdat[7:0] = s.cfg.param;
                if (wb_we_i && wb_sel_i[0]) begin
                    nx.cfg.param = wb_dat_i[7:0];
                end
            end else if (idx == `TES_IDX_DURATION) begin
                nx.rdat[7:0] = s.cfg.duration;
                if (wb_we_i && wb_sel_i[0]) begin
                    nx.cfg.duration = wb_dat_i[7:0];
                end
            end else if (idx == `TES_IDX_DEPTH) begin
                nx.rdat[7:0] = s.cfg.depth;
                if (wb_we_i && wb_sel_i[0]) begin
                    nx.cfg.depth = wb_dat_i[7:0];
                end
            end else if (idx == `TES_IDX_STATUS) begin
                nx.rdat[`TES_STAT_PHASE] = s.phase;
                nx.rdat[`TES_STAT_MOD]   = mod_sync;
                nx.rdat[`TES_STAT_K]     = s.k;
            end
        end
        // envelope sequencer: an edge always runs to completion
        case (s.phase)
            PH_HIGH: begin
                nx.amp = `TES_FULL_AMP;
                if (mod_sync) begin
                    nx.ticks = 2'h0;
                    if (n_states == 5'h00) begin
                        nx.phase = PH_LOW;
                    end else begin
                        nx.phase = PH_FALL;
                        nx.k     = 5'h01;
                    end
                end
            end
            PH_FALL: begin
                nx.amp = fall_amp;
                if (carrier_tick) begin
                    nx.ticks = adv ? 2'h0 : s.ticks + 2'h1; // R13
                end
                if (adv) begin
                    if (s.k >= n_states) begin // R14
                        nx.phase = PH_LOW;
                        nx.k     = 5'h00;
                    end else begin
                        nx.k = s.k + 5'h01; // R12
                    end
                end
            end
            PH_LOW: begin
                nx.amp = s.cfg.depth; // R16
                if (!mod_sync) begin
                    nx.ticks = 2'h0;
                    if (n_states == 5'h00) begin
                        nx.phase = PH_HIGH;
                    end else begin
                        nx.phase = PH_RISE;
                        nx.k     = 5'h01;
                    end
                end
            end
            default: begin
                nx.amp = rise_amp;
                if (carrier_tick) begin
                    nx.ticks = adv ? 2'h0 : s.ticks + 2'h1;
                end
                if (adv) begin
                    if (s.k >= n_states) begin
                        nx.phase = PH_HIGH;
                        nx.k     = 5'h00;
                    end else begin
                        nx.k = s.k + 5'h01;
                    end
                end
            end
        endcase
        nx.busy = (nx.phase == PH_FALL) || (nx.phase == PH_RISE);
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s              <= '0;
            s.cfg.select   <= `TES_RST_SELECT;
            s.cfg.param    <= `TES_RST_PARAM;
            s.cfg.duration <= `TES_RST_DURATION;
            s.cfg.depth    <= `TES_RST_DEPTH;
            s.phase        <= PH_HIGH;
            s.amp          <= `TES_FULL_AMP;
        end else begin
            s <= nx;
        end
    end

    assign wb_dat_o  = s.rdat;
    assign wb_ack_o  = s.ack;
    assign amp_out   = s.amp;
    assign edge_busy = s.busy;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_state_wait;
        s.phase == PH_FALL && stretch && carrier_tick && s.ticks == 2'h0;
    endsequence

    sequence s_state_hold;
        s.phase == PH_FALL && s.k == $past(s.k) && s.ticks == 2'h1;
    endsequence

    // reserved fall nibble must step straight to depth, whatever rise says
    property p_fall_method;
        s.phase == PH_FALL && !(s.cfg.select[7:4] inside {[4'h1:4'h6]})
            |-> fall_amp == s.cfg.depth;
    endproperty
    a_fall_method: assert property (p_fall_method) // R1
        else $error("falling edge uses wrong method nibble");

    property p_rise_method;
        s.phase == PH_RISE && !(s.cfg.select[3:0] inside {[4'h1:4'h6]})
            |-> rise_amp == `TES_FULL_AMP;
    endproperty
    a_rise_method: assert property (p_rise_method) // R2
        else $error("rising edge uses wrong method nibble");

    property p_linear_end;
        s.phase == PH_FALL && s.k == n_states && n_states != 5'h00
            && fall_cfg.method == `TES_M_LIN1 |-> fall_amp == s.cfg.depth;
    endproperty
    a_linear_end: assert property (p_linear_end) // R3
        else $error("linear ramp misses its end level");

    property p_one_cycle;
        s.phase == PH_FALL && !stretch && carrier_tick && s.k < n_states
            |=> s.k == $past(s.k) + 5'h01;
    endproperty
    a_one_cycle: assert property (p_one_cycle) // R12
        else $error("state did not last one carrier cycle");

    property p_two_cycle;
        s_state_wait |=> s_state_hold;
    endproperty
    a_two_cycle: assert property (p_two_cycle) // R13
        else $error("stretched state ended after one carrier cycle");

    property p_count_end;
        s.phase == PH_FALL && s.k == n_states && adv |=> s.phase == PH_LOW;
    endproperty
    a_count_end: assert property (p_count_end) // R14
        else $error("falling edge ran past its state count");

    property p_reserved;
        s.phase == PH_RISE && rise_cfg.method == 4'h0 |-> rise_amp == 8'hFF;
    endproperty
    a_reserved: assert property (p_reserved) // R15
        else $error("reserved method did not step at once");

    property p_depth;
        $past(s.phase) == PH_LOW && $stable(s.cfg.depth)
            |-> amp_out == s.cfg.depth;
    endproperty
    a_depth: assert property (p_depth) // R16
        else $error("low level differs from depth byte");

    property p_bus_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_bus_ack: assert property (p_bus_ack)
        else $error("bus answer not a single cycle");

endmodule

`default_nettype wire

//--- tes_edge_shaper_tb.sv
/*
 * Self-checking bench of the 212 kbit/s edge shaper: register access
 * over Wishbone, edge lengths, end levels and reserved codes.
 * Assumes tes_pkg, tes_defines.svh and the design files come first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tes_defines.svh"

`define TB_CHK(nm, e, g) begin \
    compares++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("BAD %s exp %h got %h", nm, e, g); \
    end \
end

module tes_edge_shaper_tb
    import tes_pkg::*;
;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic        mclk = 1'b0;
    logic        rst  = 1'b1;
    logic        cyc  = 1'b0;
    logic        stb  = 1'b0;
    logic        we   = 1'b0;
    logic [7:0]  adr  = 8'h00;
    logic [3:0]  sel  = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack;
    logic        pin  = 1'b0;
    logic        tick = 1'b0;
    logic [1:0]  tcnt = 2'h0;
    logic [7:0]  supply = 8'h80;
    logic [31:0] sup_s = 32'h00000021;
    logic [31:0] seed  = 32'h00000021;
    logic [7:0]  amp;
    logic        busy;
    int          miscompares = 0;
    int          compares = 0;

    always #5 mclk = ~mclk;

    tes_edge_shaper i_dut (
        .mclk             (mclk),
        .rst              (rst),
        .wb_cyc_i         (cyc),
        .wb_stb_i         (stb),
        .wb_we_i          (we),
        .wb_adr_i         (adr),
        .wb_sel_i         (sel),
        .wb_dat_i         (dat_i),
        .wb_dat_o         (dat_o),
        .wb_ack_o         (ack),
        .mod_req_pin      (pin),
        .carrier_tick     (tick),
        .power_amp_supply (supply),
        .amp_out          (amp),
        .edge_busy        (busy)
    );

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] step(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic int exp_ticks(input logic [7:0] d);
        return int'(d[4:0]) * (d[7] ? 2 : 1);
    endfunction

    function automatic logic vm(input logic [3:0] m);
        return (m >= 4'h1) && (m <= 4'h6);
    endfunction

    // carrier tick every fourth clock; supply level wanders at random
    always @(posedge mclk) begin
        tcnt   <= tcnt + 2'h1;
        tick   <= (tcnt == 2'h3);
        sup_s  <= step(sup_s);
        supply <= sup_s[7:0];
    end

    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic hang();
        miscompares++;
        $display("BAD wait exp %h got %h", 1, 0);
        test_done();
    endtask

    // classic single cycle; called just after a rising edge
    task automatic wb(input logic w, input logic [5:0] ix,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        int i;
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= {ix, 2'b00};
        sel   <= s;
        dat_i <= d;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (ack !== 1'b1 && i < 20);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (ack !== 1'b1)
            hang();
        @(posedge mclk);
    endtask

    // one edge: count ticks while busy, watch range, check end level
    task automatic edge_run(input logic lvl, input logic [7:0] lo,
                            input logic [7:0] e_amp, input int e_t,
                            input logic chk_t);
        int   i;
        int   n;
        logic inr;
        n   = 0;
        inr = 1'b1;
        pin <= lvl;
        for (i = 0; i < 8 && busy !== 1'b1; i++)
            @(negedge mclk);
        for (i = 0; i < 600 && busy === 1'b1; i++) begin
            if (tick === 1'b1)
                n++;
            if ((amp < lo) !== 1'b0)
                inr = 1'b0;
            @(negedge mclk);
        end
        if (i == 600)
            hang();
        repeat (3) @(posedge mclk);
        if (chk_t)
            `TB_CHK("edge ticks", e_t, n)
        `TB_CHK("ramp range", 1'b1, inr)
        `TB_CHK("end level", e_amp, amp)
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    logic [5:0]  ix [4] = '{`TES_IDX_SELECT, `TES_IDX_PARAM,
                           `TES_IDX_DURATION, `TES_IDX_DEPTH};
    logic [7:0]  rv [4] = '{8'h11, 8'h00, 8'h08, 8'h00};
    logic [7:0]  stab [10] = '{8'h16, 8'h25, 8'h34, 8'h43, 8'h52,
                              8'h61, 8'h7F, 8'hC0, 8'h36, 8'h14};
    logic [31:0] q;
    logic [31:0] q2;
    logic [31:0] r;
    logic [7:0]  dur;

    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        `TB_CHK("amp after reset", 8'hFF, amp)
        `TB_CHK("busy after reset", 1'b0, busy)
        for (int j = 0; j < 4; j++) begin
            wb(1'b0, ix[j], 32'h0, 4'hF, q);
            `TB_CHK("reset value", {24'h0, rv[j]}, q)
        end
        // random write, then a write with sel[0] low, then read back
        for (int j = 0; j < 4; j++) begin
            seed = step(seed);
            wb(1'b1, ix[j], seed, 4'hF, q);
            wb(1'b1, ix[j], ~seed, 4'hE, q);
            wb(1'b0, ix[j], 32'h0, 4'hF, q);
            `TB_CHK("reg readback", {24'h0, seed[7:0]}, q)
        end
        // unmapped place reads zero; status ignores writes
        wb(1'b1, 6'h10, 32'hFFFFFFFF, 4'hF, q);
        wb(1'b0, 6'h10, 32'h0, 4'hF, q);
        `TB_CHK("unmapped", 32'h0, q)
        wb(1'b0, `TES_IDX_STATUS, 32'h0, 4'hF, q2);
        wb(1'b1, `TES_IDX_STATUS, 32'hFFFFFFFF, 4'hF, q);
        wb(1'b0, `TES_IDX_STATUS, 32'h0, 4'hF, q);
        `TB_CHK("status ro", q2, q)
        `TB_CHK("status idle", 3'h0, q[2:0])
        // every method on each edge, reserved codes and bits, limits
        for (int j = 0; j < 10; j++) begin
            seed = step(seed);
            r = seed;
            dur = {r[8], r[10:9], 5'(r[2:0]) + 5'h01};
            if (j == 8)
                dur = 8'h9F;
            if (j == 9)
                dur = 8'h80;
            wb(1'b1, `TES_IDX_SELECT, {24'h0, stab[j]}, 4'hF, q);
            wb(1'b1, `TES_IDX_PARAM, {24'h0, r[23:16]}, 4'hF, q);
            wb(1'b1, `TES_IDX_DURATION, {24'h0, dur}, 4'hF, q);
            wb(1'b1, `TES_IDX_DEPTH, {24'h0, r[31:24]}, 4'hF, q);
            edge_run(1'b1, r[31:24], r[31:24], exp_ticks(dur),
                     vm(stab[j][7:4]));
            // low phase, request seen, state count back at zero
            wb(1'b0, `TES_IDX_STATUS, 32'h0, 4'hF, q);
            `TB_CHK("status low", {5'h00, 1'b1, 2'h2}, q[7:0])
            edge_run(1'b0, r[31:24], 8'hFF, exp_ticks(dur),
                     vm(stab[j][3:0]));
        end
        test_done();
    end

    initial begin
        repeat (60000) @(posedge mclk);
        hang();
    end
endmodule

`default_nettype wire
